// ---- src/ptpi_pkg.sv ----
// Shared constants for the period timer, postscaler and interrupt block
package ptpi_pkg;
    // Instance count and data widths
    localparam int PTPI_NUM_TIMERS = 3;
    localparam int PTPI_CNT_W = 8;
    localparam int PTPI_PRE_W = 6;
    localparam int PTPI_POST_W = 4;
    // Instruction clock divider from the system clock
    localparam int PTPI_INSTR_DIV = 4;
    // Register byte offsets; one timer per 16-byte slot
    localparam logic [7:0] PTPI_SLOT_STRIDE = 8'h10;
    localparam logic [1:0] PTPI_REG_COUNT = 2'h0;
    localparam logic [1:0] PTPI_REG_PERIOD = 2'h1;
    localparam logic [1:0] PTPI_REG_CONTROL = 2'h2;
    localparam logic [7:0] PTPI_OFF_FLAG = 8'h30;
    localparam logic [7:0] PTPI_OFF_ENABLE = 8'h34;
    localparam logic [7:0] PTPI_OFF_CONFIG = 8'h38;
    // Control and config register fields
    localparam int PTPI_CTL_PRE_LSB = 0;
    localparam int PTPI_CTL_RUN_BIT = 2;
    localparam int PTPI_CTL_POST_LSB = 3;
    localparam int PTPI_CTL_UNUSED_BIT = 7;
    localparam int PTPI_CFG_SHIFT_SEL_BIT = 0;
    // Reset values
    localparam logic [7:0] PTPI_COUNT_RST = 8'h00;
    localparam logic [7:0] PTPI_PERIOD_RST = 8'hff;
    localparam logic [7:0] PTPI_CONTROL_RST = 8'h00;
    // Prescaler codes
    localparam logic [1:0] PTPI_PRE_DIV1 = 2'h0;
    localparam logic [1:0] PTPI_PRE_DIV4 = 2'h1;
    localparam logic [1:0] PTPI_PRE_DIV16 = 2'h2;
    localparam logic [1:0] PTPI_PRE_DIV64 = 2'h3;
    localparam logic [5:0] PTPI_PRE_TC1 = 6'h00;
    localparam logic [5:0] PTPI_PRE_TC4 = 6'h03;
    localparam logic [5:0] PTPI_PRE_TC16 = 6'h0f;
    localparam logic [5:0] PTPI_PRE_TC64 = 6'h3f;
    // AHB-Lite codes
    localparam logic [1:0] PTPI_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] PTPI_HSIZE_WORD = 3'h2;
    // Bus read sequencer states
    typedef enum logic [1:0] {
        PTPI_BUS_IDLE = 2'b01,
        PTPI_BUS_RWAIT = 2'b10
    } ptpi_bus_state_t;
endpackage

// ---- src/ptpi_timer_core.sv ----
// Prescaler, 8-bit time base counter and period match for one timer
`timescale 1ns/1ps
module ptpi_timer_core import ptpi_pkg::*; #(
    parameter int CNT_W = PTPI_CNT_W
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic tick,
    input wire logic [1:0] prescale_select,
    input wire logic clear_scalers,
    // Counter write and period
    input wire logic count_wr,
    input wire logic [CNT_W-1:0] count_wdata,
    input wire logic [CNT_W-1:0] period_value,
    // Results
    output logic [CNT_W-1:0] time_base_count,
    output logic match_pulse
);
    logic [PTPI_PRE_W-1:0] pre_cnt;
    logic [PTPI_PRE_W-1:0] pre_tc;
    logic pre_done;

    // Terminal count of the prescaler
    always_comb begin
        case (prescale_select)
            PTPI_PRE_DIV1: pre_tc = PTPI_PRE_TC1; // [R11]
            PTPI_PRE_DIV4: pre_tc = PTPI_PRE_TC4;
            PTPI_PRE_DIV16: pre_tc = PTPI_PRE_TC16;
            PTPI_PRE_DIV64: pre_tc = PTPI_PRE_TC64;
            default: pre_tc = PTPI_PRE_TC1;
        endcase
    end
    assign pre_done = tick && (pre_cnt >= pre_tc);

    // Prescaler counter, cleared by counter or control writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pre_cnt <= '0;
        end else if (clk_en) begin
            if (clear_scalers || count_wr) begin
                pre_cnt <= '0; // [R16]
            end else if (pre_done) begin
                pre_cnt <= '0;
            end else if (tick) begin
                pre_cnt <= pre_cnt + 1'b1;
            end
        end
    end

    // Time base counter: counts up, returns to zero after a match
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            time_base_count <= '0; // [R17]
            match_pulse <= 1'b0;
        end else if (clk_en) begin
            match_pulse <= 1'b0;
            if (count_wr) begin
                time_base_count <= count_wdata;
            end else if (pre_done) begin
                if (time_base_count == period_value) begin
                    time_base_count <= '0; // [R15]
                    match_pulse <= 1'b1;
                end else begin
                    time_base_count <= time_base_count + 1'b1; // [R14]
                end
            end
        end
    end
endmodule // ptpi_timer_core

// ---- src/ptpi_postscaler.sv ----
// Match postscaler producing the interrupt event every n+1 matches
`timescale 1ns/1ps
module ptpi_postscaler import ptpi_pkg::*; #(
    parameter int POST_W = PTPI_POST_W
) (
    // Clock and control
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic clear_scalers,
    input wire logic [POST_W-1:0] postscale_select,
    // Match in, event out
    input wire logic match_pulse,
    output logic event_pulse
);
    logic [POST_W-1:0] post_cnt;

    // Count matches; terminal count equals the select value
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            post_cnt <= '0;
            event_pulse <= 1'b0;
        end else if (clk_en) begin
            event_pulse <= 1'b0;
            if (clear_scalers) begin
                post_cnt <= '0; // [R16]
            end else if (match_pulse) begin
                if (post_cnt >= postscale_select) begin
                    post_cnt <= '0; // [R1] [R4] [R5]
                    event_pulse <= 1'b1;
                end else begin
                    post_cnt <= post_cnt + 1'b1;
                end
            end
        end
    end
endmodule // ptpi_postscaler

// ---- src/ptpi_top.sv ----
// Three period timers with postscalers, interrupt flags and AHB-Lite registers
//
// Functional notes
// R1: Match pulses feed a 4-bit postscaler
// R2: Postscaler terminal count sets sticky match flag
// R3: Flag raises interrupt only when enabled
// R4: Sixteen postscale ratios, one to sixteen
// R5: Select value n gives n+1 matches
// R6: Unscaled match goes to compare/PWM units
// R7: First match may clock serial port
// R8: No counting or matches during sleep
// R9: Counter and period kept through sleep
// R10: Control bit 2 runs the timer
// R11: Prescale codes divide by 1,4,16,64
// R12: Control bit 7 reads as zero
// R13: Software-readable 8-bit counter per timer
// R14: Counts up on instruction clock ticks
// R15: Match resets counter to zero next
// R16: Counter/control writes and reset clear scalers
// R17: Reset clears counter, period becomes FFh
// R18: Software clears the flag itself
// R19: Control resets to zero
`timescale 1ns/1ps
module ptpi_top import ptpi_pkg::*; #(
    parameter int NUM_TIMERS = PTPI_NUM_TIMERS,
    parameter int INSTR_DIV = PTPI_INSTR_DIV
) (
    // Clock, reset, clock enable
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Processor state
    input wire logic sleep,
    input wire logic spi_mode,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Timer outputs
    output logic [NUM_TIMERS-1:0] match_out,
    output logic ssp_shift_clk,
    output logic irq
);
    ptpi_bus_state_t bus_state;
    logic [$clog2(INSTR_DIV+1)-1:0] instr_cnt;
    logic instr_tick;
    logic run_tick [NUM_TIMERS];
    logic [7:0] period_value [NUM_TIMERS];
    logic [7:0] timer_control [NUM_TIMERS];
    logic [7:0] time_base_count [NUM_TIMERS];
    logic [NUM_TIMERS-1:0] match_pulse;
    logic [NUM_TIMERS-1:0] post_event;
    logic [NUM_TIMERS-1:0] clear_scalers;
    logic [NUM_TIMERS-1:0] count_wr;
    logic [NUM_TIMERS-1:0] periph_flag_reg;
    logic [NUM_TIMERS-1:0] periph_enable_reg;
    logic shift_clk_select;
    logic wr_pending;
    logic [7:0] wr_addr;
    logic addr_ok;
    logic [31:0] rd_value;
    logic [NUM_TIMERS-1:0] flag_w1c;

    // Address phase accepted for a word transfer to this slave
    assign addr_ok = hsel && hready && (htrans == PTPI_HTRANS_NONSEQ)
        && (hsize == PTPI_HSIZE_WORD);

    // Instruction clock tick, one system clock in INSTR_DIV
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            instr_cnt <= '0;
        end else if (clk_en) begin
            if (instr_cnt == ($clog2(INSTR_DIV+1))'(INSTR_DIV - 1)) begin
                instr_cnt <= '0;
            end else begin
                instr_cnt <= instr_cnt + 1'b1;
            end
        end
    end
    assign instr_tick = (instr_cnt == ($clog2(INSTR_DIV+1))'(INSTR_DIV - 1)); // [R14]

    // Bus sequencer: writes take no wait, reads one wait state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bus_state <= PTPI_BUS_IDLE;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pending <= 1'b0;
            wr_addr <= '0;
        end else if (clk_en) begin
            hresp <= 1'b0;
            case (bus_state)
                PTPI_BUS_IDLE: begin
                    wr_pending <= addr_ok && hwrite;
                    wr_addr <= haddr;
                    if (addr_ok && !hwrite) begin
                        bus_state <= PTPI_BUS_RWAIT;
                        hreadyout <= 1'b0;
                    end
                end
                PTPI_BUS_RWAIT: begin
                    wr_pending <= 1'b0;
                    bus_state <= PTPI_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default: begin
                    wr_pending <= 1'b0;
                    bus_state <= PTPI_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end

    // Read mux over the latched address, unmapped reads as zero
    always_comb begin
        rd_value = '0;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (wr_addr[7:4] == 4'(i) && wr_addr[1:0] == 2'h0) begin
                case (wr_addr[3:2])
                    PTPI_REG_COUNT: rd_value = {24'h00_0000, time_base_count[i]}; // [R13]
                    PTPI_REG_PERIOD: rd_value = {24'h00_0000, period_value[i]};
                    PTPI_REG_CONTROL: rd_value = {24'h00_0000, timer_control[i]}; // [R12]
                    default: rd_value = '0;
                endcase
            end
        end
        if (wr_addr == PTPI_OFF_FLAG) begin
            rd_value = 32'(periph_flag_reg);
        end
        if (wr_addr == PTPI_OFF_ENABLE) begin
            rd_value = 32'(periph_enable_reg);
        end
        if (wr_addr == PTPI_OFF_CONFIG) begin
            rd_value = 32'(shift_clk_select);
        end
    end

    // Read data, loaded in the wait state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hrdata <= '0;
        end else if (clk_en) begin
            if (bus_state == PTPI_BUS_RWAIT) begin
                hrdata <= rd_value;
            end
        end
    end

    // Write strobes decoded per timer
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            count_wr[i] = wr_pending && (wr_addr == 8'(i * 16));
            clear_scalers[i] = wr_pending
                && (wr_addr == 8'(i * 16 + 8) || wr_addr == 8'(i * 16)); // [R16]
        end
        flag_w1c = (wr_pending && wr_addr == PTPI_OFF_FLAG)
            ? hwdata[NUM_TIMERS-1:0] : '0;
    end

    // Period and control registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                period_value[i] <= PTPI_PERIOD_RST; // [R17]
                timer_control[i] <= PTPI_CONTROL_RST; // [R19]
            end
        end else if (clk_en && wr_pending) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (wr_addr == 8'(i * 16 + 4)) begin
                    period_value[i] <= hwdata[7:0];
                end
                if (wr_addr == 8'(i * 16 + 8)) begin
                    timer_control[i] <= {1'b0, hwdata[6:0]}; // [R12]
                end
            end
        end
    end

    // Enable mask and shift clock select
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            periph_enable_reg <= '0;
            shift_clk_select <= 1'b0;
        end else if (clk_en && wr_pending) begin
            if (wr_addr == PTPI_OFF_ENABLE) begin
                periph_enable_reg <= hwdata[NUM_TIMERS-1:0];
            end
            if (wr_addr == PTPI_OFF_CONFIG) begin
                shift_clk_select <= hwdata[PTPI_CFG_SHIFT_SEL_BIT];
            end
        end
    end

    // Timers and postscalers, one pair per instance
    for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_timer
        // Ticks stop in sleep or when not running, so state holds
        assign run_tick[g] = instr_tick && !sleep
            && timer_control[g][PTPI_CTL_RUN_BIT]; // [R8] [R9] [R10]

        ptpi_timer_core u_core (
            .clk(clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .tick(run_tick[g]),
            .prescale_select(timer_control[g][PTPI_CTL_PRE_LSB +: 2]), // [R11]
            .clear_scalers(clear_scalers[g]),
            .count_wr(count_wr[g]),
            .count_wdata(hwdata[7:0]),
            .period_value(period_value[g]),
            .time_base_count(time_base_count[g]),
            .match_pulse(match_pulse[g])
        );

        ptpi_postscaler u_post (
            .clk(clk),
            .reset_n(reset_n),
            .clk_en(clk_en),
            .clear_scalers(clear_scalers[g]),
            .postscale_select(timer_control[g][PTPI_CTL_POST_LSB +: PTPI_POST_W]), // [R5]
            .match_pulse(match_pulse[g]), // [R1]
            .event_pulse(post_event[g])
        );
    end

    // Sticky match flags; a new event wins over a clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            periph_flag_reg <= '0;
        end else if (clk_en) begin
            periph_flag_reg <= (periph_flag_reg & ~flag_w1c) | post_event; // [R2] [R18]
        end
    end

    // Interrupt, unscaled match and shift clock outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            irq <= 1'b0;
            match_out <= '0;
            ssp_shift_clk <= 1'b0;
        end else if (clk_en) begin
            irq <= |(periph_flag_reg & periph_enable_reg); // [R3]
            match_out <= match_pulse; // [R6]
            ssp_shift_clk <= match_pulse[0] && shift_clk_select && spi_mode; // [R7]
        end
    end
endmodule // ptpi_top

// ---- sim/ptpi_checker.sv ----
// Bus, match and interrupt checks for the period timer block
`timescale 1ns/1ps
module ptpi_checker import ptpi_pkg::*; #(
    parameter int NUM_TIMERS = PTPI_NUM_TIMERS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Inputs watched
    input wire logic sleep,
    input wire logic spi_mode,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    // Outputs watched
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [NUM_TIMERS-1:0] match_out,
    input wire logic ssp_shift_clk,
    input wire logic irq
);
    // Accepted word transfers
    logic taken;
    assign taken = hsel && hready && htrans == PTPI_HTRANS_NONSEQ && hsize == PTPI_HSIZE_WORD;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Bus handshake
    a_resp_always_okay: assert property (!hresp)
        else $error("bus response not okay");
    a_read_one_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait not one cycle");
    a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    // Match pulses, one instruction tick apart at least
    a_match_spaced: assert property ((match_out & ($past(match_out)
        | $past(match_out, 2) | $past(match_out, 3))) == '0)
        else $error("match pulses too close");
    a_shift_from_match: assert property (ssp_shift_clk |-> match_out[0] && $past(spi_mode))
        else $error("shift clock without timer0 match");
    a_sleep_frozen: assert property (sleep [*4] |-> match_out == '0 && !ssp_shift_clk)
        else $error("match during sleep");
    // Interrupt line moves only for a cause
    a_irq_rise_cause: assert property ($rose(irq) |->
        $past(|match_out, 2) || $past(taken && hwrite, 3))
        else $error("interrupt rose without cause");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(taken && hwrite, 3))
        else $error("interrupt fell without write");
endmodule // ptpi_checker

bind ptpi_top ptpi_checker #(.NUM_TIMERS(NUM_TIMERS)) ptpi_checker_i (.clk, .reset_n,
    .sleep, .spi_mode, .hsel, .htrans, .hwrite, .hsize, .hready, .hreadyout, .hresp,
    .match_out, .ssp_shift_clk, .irq);

// ---- sim/ptpi_ccp_model.sv ----
// Compare/PWM units and serial port stand-in counting timer pulses
`timescale 1ns/1ps
module ptpi_far_model import ptpi_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Time base and shift clock from the timers
    input wire logic [PTPI_NUM_TIMERS-1:0] match_out,
    input wire logic ssp_shift_clk,
    // Pulses taken in
    output int base_ticks [PTPI_NUM_TIMERS],
    output int shift_ticks
);
    // One time base step per unscaled match, one shift per clock pulse
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            base_ticks <= '{default: 0};
            shift_ticks <= 0;
        end else begin
            for (int i = 0; i < PTPI_NUM_TIMERS; i++) begin
                base_ticks[i] <= base_ticks[i] + int'(match_out[i]);
            end
            shift_ticks <= shift_ticks + int'(ssp_shift_clk);
        end
    end
endmodule // ptpi_far_model

// ---- sim/ptpi_tb_top.sv ----
// Self-checking bench for the period timer, postscaler and interrupt block
`timescale 1ns/1ps
module ptpi_tb_top import ptpi_pkg::*;;
    // Design side signals
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic sleep, spi_mode, hsel, hwrite, hreadyout, hresp, ssp_shift_clk, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, match_out;
    logic [31:0] hwdata, hrdata, rd;
    logic [31:0] rs = 32'h0000_0016;
    int base_ticks [PTPI_NUM_TIMERS];
    int shift_ticks, miscompares = 0, n_tests = 0, cyc = 0, b, s, n, per, t;

    always #5 clk = ~clk;

    ptpi_top ptpi_top_i (.clk, .reset_n, .clk_en(1'b1), .sleep, .spi_mode, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .match_out, .ssp_shift_clk, .irq);
    ptpi_far_model ptpi_far_model_i (.clk, .reset_n, .match_out, .ssp_shift_clk,
        .base_ticks, .shift_ticks);

    // Seeded pseudo-random source
    function automatic logic [31:0] xorshift();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction

    // Register address of timer i
    function automatic logic [7:0] ra(input int i, input logic [1:0] r);
        return 8'(i) * PTPI_SLOT_STRIDE + 8'({r, 2'b00});
    endfunction

    // Control word from postscale, run and prescale
    function automatic logic [31:0] ctl(input int post, input int run, input int pre);
        return 32'((post << PTPI_CTL_POST_LSB) | (run << PTPI_CTL_RUN_BIT) | pre);
    endfunction

    task automatic end_sim();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite word transfer, read data into rd
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= PTPI_HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= PTPI_HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // Cycles up to the next match of timer 2
    task automatic wait_match();
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (match_out[2] !== 1'b1 && t < 3000);
    endtask

    // Run limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            end_sim();
        end
    end

    initial begin
        {sleep, spi_mode, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        // Reset values, unimplemented bit, unmapped place
        for (int i = 0; i < 3; i++) begin
            bus(ra(i, PTPI_REG_COUNT), 1'b0, 0);
            chk(rd, 32'h0000_0000);
            bus(ra(i, PTPI_REG_PERIOD), 1'b0, 0);
            chk(rd, 32'h0000_00ff);
            bus(ra(i, PTPI_REG_CONTROL), 1'b0, 0);
            chk(rd, 32'h0000_0000);
        end
        bus(ra(1, PTPI_REG_CONTROL), 1'b1, 32'h0000_00fb);
        bus(ra(1, PTPI_REG_CONTROL), 1'b0, 0);
        chk(rd, 32'h0000_007b);
        bus(8'h3c, 1'b0, 0);
        chk(rd, 32'h0000_0000);
        $display("test reset values done");
        // Postscale ratios: first, last and random selects
        bus(ra(1, PTPI_REG_PERIOD), 1'b1, 0);
        bus(PTPI_OFF_ENABLE, 1'b1, 32'h0000_0007);
        for (int k = 0; k < 4; k++) begin
            n = (k == 0) ? 0 : (k == 1) ? 15 : int'(xorshift() % 16);
            bus(ra(1, PTPI_REG_CONTROL), 1'b1, 0);
            bus(PTPI_OFF_FLAG, 1'b1, 32'h0000_0007);
            b = base_ticks[1];
            bus(ra(1, PTPI_REG_CONTROL), 1'b1, ctl(n, 1, 0));
            for (t = 0; t < 400 && irq !== 1'b1; t++) @(posedge clk);
            chk(base_ticks[1] - b, n + 1);
            bus(ra(1, PTPI_REG_CONTROL), 1'b1, 0);
            repeat (8) @(posedge clk);
            chk(irq, 1'b1);
            bus(PTPI_OFF_FLAG, 1'b0, 0);
            chk(rd, 32'h0000_0002);
            bus(PTPI_OFF_FLAG, 1'b1, 32'h0000_0002);
            repeat (2) @(posedge clk);
            chk(irq, 1'b0);
        end
        $display("test postscaler done");
        // Masked flag raises no interrupt until enabled
        bus(PTPI_OFF_ENABLE, 1'b1, 0);
        bus(ra(1, PTPI_REG_CONTROL), 1'b1, ctl(0, 1, 0));
        repeat (20) @(posedge clk);
        bus(PTPI_OFF_FLAG, 1'b0, 0);
        chk(rd, 32'h0000_0002);
        chk(irq, 1'b0);
        bus(PTPI_OFF_ENABLE, 1'b1, 32'h0000_0002);
        repeat (3) @(posedge clk);
        chk(irq, 1'b1);
        bus(ra(1, PTPI_REG_CONTROL), 1'b1, 0);
        bus(PTPI_OFF_FLAG, 1'b1, 32'h0000_0007);
        $display("test interrupt mask done");
        // Prescale codes and period length
        for (int p = 0; p < 4; p++) begin
            per = int'(xorshift() % 4);
            bus(ra(2, PTPI_REG_PERIOD), 1'b1, 32'(per));
            bus(ra(2, PTPI_REG_COUNT), 1'b1, 0); // Start at or below the new period
            bus(ra(2, PTPI_REG_CONTROL), 1'b1, ctl(0, 1, p));
            wait_match();
            wait_match();
            chk(t, PTPI_INSTR_DIV * (1 << (2 * p)) * (per + 1));
            bus(ra(2, PTPI_REG_CONTROL), 1'b1, 0);
        end
        $display("test prescaler done");
        // Sleep and run bit freeze the counter
        bus(ra(0, PTPI_REG_CONTROL), 1'b1, ctl(0, 1, 0));
        repeat (40) @(posedge clk);
        sleep <= 1'b1;
        repeat (4) @(posedge clk);
        b = base_ticks[0];
        bus(ra(0, PTPI_REG_COUNT), 1'b0, 0);
        n = int'(rd);
        repeat (50) @(posedge clk);
        bus(ra(0, PTPI_REG_COUNT), 1'b0, 0);
        chk(rd, 32'(n));
        chk(base_ticks[0] - b, 0);
        bus(ra(0, PTPI_REG_PERIOD), 1'b0, 0);
        chk(rd, 32'h0000_00ff);
        sleep <= 1'b0;
        repeat (20) @(posedge clk);
        bus(ra(0, PTPI_REG_COUNT), 1'b0, 0);
        chk(32'(rd == 32'(n)), 0);
        bus(ra(0, PTPI_REG_CONTROL), 1'b1, 0);
        bus(ra(0, PTPI_REG_COUNT), 1'b1, 32'h0000_005a);
        repeat (20) @(posedge clk);
        bus(ra(0, PTPI_REG_COUNT), 1'b0, 0);
        chk(rd, 32'h0000_005a);
        $display("test sleep done");
        // Timer0 match as serial shift clock, with and without SPI mode
        bus(ra(0, PTPI_REG_PERIOD), 1'b1, 0);
        bus(PTPI_OFF_CONFIG, 1'b1, 32'h0000_0001);
        bus(ra(0, PTPI_REG_COUNT), 1'b1, 0); // Count left at 5a would miss period 0
        for (int m = 1; m >= 0; m--) begin
            spi_mode <= m[0];
            b = base_ticks[0];
            s = shift_ticks;
            bus(ra(0, PTPI_REG_CONTROL), 1'b1, ctl(0, 1, 0));
            repeat (60) @(posedge clk);
            bus(ra(0, PTPI_REG_CONTROL), 1'b1, 0);
            repeat (4) @(posedge clk);
            chk(32'(base_ticks[0] - b > 10), 1);
            chk(shift_ticks - s, m * (base_ticks[0] - b));
        end
        $display("test shift clock done");
        end_sim();
    end
endmodule // ptpi_tb_top
